/* verilog/crc_pkg.sv */
// Package with register map, field positions, reset values and types of the CRC block
package crc_pkg;

    // ----------------------------------------------------------------
    // Register word indices (word index = addr[4:2] of the byte address)
    // ----------------------------------------------------------------
    localparam logic [2:0] IDX_CONL    = 3'h0;
    localparam logic [2:0] IDX_CONH    = 3'h1;
    localparam logic [2:0] IDX_XORL    = 3'h2;
    localparam logic [2:0] IDX_XORH    = 3'h3;
    localparam logic [2:0] IDX_DATA    = 3'h4;
    localparam logic [2:0] IDX_RESULT  = 3'h5;
    localparam logic [2:0] IDX_IRQSTAT = 3'h6;
    localparam logic [2:0] IDX_IRQMASK = 3'h7;

    // ----------------------------------------------------------------
    // Control low and high field positions
    // ----------------------------------------------------------------
    localparam int BIT_EN     = 15;
    localparam int BIT_SIDL   = 13;
    localparam int BIT_CNT_LO = 8;
    localparam int BIT_FULL   = 7;
    localparam int BIT_EMPTY  = 6;
    localparam int BIT_ISEL   = 5;
    localparam int BIT_GO     = 4;
    localparam int BIT_LSB    = 3;
    localparam int BIT_MOD    = 2;
    localparam int BIT_DW_LO  = 8;

    // Interrupt status bits
    localparam int IRQ_EMPTY = 0;
    localparam int IRQ_DONE  = 1;

    // ----------------------------------------------------------------
    // Sizes and reset values
    // ----------------------------------------------------------------
    localparam int         FIFO_DEPTH   = 16;
    localparam logic [4:0] FIFO_MAX_BIG = 5'h08;
    localparam logic [4:0] FIFO_MAX_SML = 5'h10;
    localparam logic [4:0] POLY_LENGTH_FIELD_SPLIT   = 5'h07;
    localparam logic [31:0] POLY_RESET  = 32'h0000_0000;
    localparam logic [1:0] IRQ_RESET    = 2'h0;

    typedef struct packed {
        logic       enable;
        logic       stop_in_idle;
        logic       irq_sel;
        logic       lsb_first;
        logic       alt_mode;
        logic [4:0] data_width_field;
        logic [4:0] poly_length_field;
    } crc_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE  = 3'b100
    } eng_state_t;

endpackage

/* verilog/crc_control.sv */
// Programmable CRC control, data FIFO, serial shift engine and Avalon-MM slave
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module crc_control (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        device_idle,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    crc_pkg::crc_cfg_t   cfg_q, cfg_d;
    crc_pkg::eng_state_t st_q, st_d;
    logic        go_q, go_d;
    logic [31:0] poly_q, poly_d;
    logic [31:0] crc_q, crc_d;
    logic [31:0] word_q, word_d;
    logic [4:0]  bits_q, bits_d;
    logic [31:0] fifo_mem [crc_pkg::FIFO_DEPTH];
    logic [3:0]  rd_ptr_q, rd_ptr_d, wr_ptr_q, wr_ptr_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [1:0]  irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;

    // Byte-lane merge used by the polynomial and result registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Derived control
    // ----------------------------------------------------------------
    logic        run;
    logic [4:0]  fifo_max;
    logic        fifo_full, fifo_empty;
    logic        req, wr_acc, rd_cap;
    logic [2:0]  idx;
    logic        push, pop;
    logic        fb;
    logic        in_bit;
    logic [31:0] crc_shift;
    logic [31:0] len_mask;

    assign run        = cfg_q.enable && !(cfg_q.stop_in_idle && device_idle);
    assign fifo_max   = (cfg_q.poly_length_field >= crc_pkg::POLY_LENGTH_FIELD_SPLIT)
                        ? crc_pkg::FIFO_MAX_BIG : crc_pkg::FIFO_MAX_SML;
    assign fifo_full  = (cnt_q >= fifo_max);
    assign fifo_empty = (cnt_q == 5'h00);
    assign req        = avs_read || avs_write;
    assign idx        = avs_address[4:2];
    // One wait state: read data are registered during it, so they stand at the
    // edge where waitrequest is low, at the price of one cycle of latency
    assign avs_waitrequest = req && !ack_q;
    assign wr_acc     = avs_write && ack_q;
    assign rd_cap     = avs_read && !ack_q;
    // Writes to a full FIFO are dropped rather than stalling the bus
    assign push       = wr_acc && (idx == crc_pkg::IDX_DATA) && avs_byteenable[0] && !fifo_full;
    // A pop waits for the shifter to finish the word in hand
    assign pop        = run && (st_q != crc_pkg::ST_SHIFT) && go_q && !fifo_empty;
    // The register keeps only the low length bits; higher bits stay zero
    assign len_mask   = ~(32'hffff_fffe << cfg_q.poly_length_field);
    // Direction picks which end of the word enters first
    assign in_bit     = cfg_q.lsb_first ? word_q[0] : word_q[cfg_q.data_width_field];

    // Legacy: feedback from the top of the register; alternate: data XOR applied
    // after the shift (augmented form), so the shift-out is delayed by the length.
    // The x^0 term is always fed back; its enable bit is not stored
    always_comb begin
        crc_shift = crc_q;
        fb        = 1'b0;
        if (cfg_q.alt_mode) begin
            fb        = crc_q[cfg_q.poly_length_field];
            crc_shift = ({crc_q[30:0], in_bit}) ^ (fb ? (poly_q | 32'h0000_0001) : 32'h0);
        end else begin
            fb        = crc_q[cfg_q.poly_length_field] ^ in_bit;
            crc_shift = ({crc_q[30:0], 1'b0}) ^ (fb ? (poly_q | 32'h0000_0001) : 32'h0);
        end
        crc_shift = crc_shift & len_mask;
    end

    // ----------------------------------------------------------------
    // Engine and FIFO next state
    // ----------------------------------------------------------------
    // Per word: one cycle in idle or done to pop, width+1 shift cycles, then done.
    // Popping straight from done keeps back-to-back words one cycle apart, so a
    // full FIFO drains without the start bit ever being rewritten.
    always_comb begin
        st_d     = st_q;
        go_d     = go_q;
        crc_d    = crc_q;
        word_d   = word_q;
        bits_d   = bits_q;
        rd_ptr_d = rd_ptr_q;
        wr_ptr_d = push ? wr_ptr_q + 4'h1 : wr_ptr_q;
        cnt_d    = cnt_q;
        if (!cfg_q.enable) begin
            st_d  = crc_pkg::ST_IDLE;
            go_d  = 1'b0;
        end else if (run) begin
            case (st_q)
                crc_pkg::ST_IDLE, crc_pkg::ST_DONE: begin
                    if (pop) begin
                        word_d   = fifo_mem[rd_ptr_q];
                        rd_ptr_d = rd_ptr_q + 4'h1;
                        bits_d   = cfg_q.data_width_field;
                        st_d     = crc_pkg::ST_SHIFT;
                    end else if (st_q == crc_pkg::ST_DONE) begin
                        st_d = crc_pkg::ST_IDLE;
                    end
                end
                crc_pkg::ST_SHIFT: begin
                    crc_d  = crc_shift;
                    word_d = cfg_q.lsb_first ? {1'b0, word_q[31:1]} : {word_q[30:0], 1'b0};
                    bits_d = bits_q - 5'h01;
                    if (bits_q == 5'h00) begin
                        st_d = crc_pkg::ST_DONE;
                        if (fifo_empty) begin
                            go_d = 1'b0;
                        end
                    end
                end
                default: st_d = crc_pkg::ST_IDLE;
            endcase
        end
        cnt_d = cnt_q + {4'h0, push} - {4'h0, pop};
        if (wr_acc && idx == crc_pkg::IDX_CONL && avs_byteenable[0]) begin
            go_d = avs_writedata[crc_pkg::BIT_GO];
        end
        if (wr_acc && idx == crc_pkg::IDX_RESULT) begin
            crc_d = lane_merge(crc_q, avs_writedata, avs_byteenable) & len_mask;
        end
    end

    // ----------------------------------------------------------------
    // Registers, interrupts and bus next state
    // ----------------------------------------------------------------
    logic ev_empty, ev_done;
    // Empty event as the last word leaves the FIFO, while it still shifts
    assign ev_empty = pop && (cnt_q == 5'h01) && cfg_q.irq_sel;
    assign ev_done  = (st_q == crc_pkg::ST_SHIFT) && (bits_q == 5'h00)
                      && run && !cfg_q.irq_sel;

    always_comb begin
        cfg_d      = cfg_q;
        poly_d     = poly_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        ack_d      = req && !ack_q;
        rdata_d    = 32'h0000_0000;
        if (wr_acc) begin
            case (idx)
                crc_pkg::IDX_CONL: begin
                    if (avs_byteenable[1]) begin
                        cfg_d.enable       = avs_writedata[crc_pkg::BIT_EN];
                        cfg_d.stop_in_idle = avs_writedata[crc_pkg::BIT_SIDL];
                    end
                    if (avs_byteenable[0]) begin
                        cfg_d.irq_sel   = avs_writedata[crc_pkg::BIT_ISEL];
                        cfg_d.lsb_first = avs_writedata[crc_pkg::BIT_LSB];
                        cfg_d.alt_mode  = avs_writedata[crc_pkg::BIT_MOD];
                    end
                end
                crc_pkg::IDX_CONH: begin
                    if (avs_byteenable[1]) begin
                        cfg_d.data_width_field = avs_writedata[12:8];
                    end
                    if (avs_byteenable[0]) begin
                        cfg_d.poly_length_field = avs_writedata[4:0];
                    end
                end
                crc_pkg::IDX_XORL: begin
                    poly_d = lane_merge(poly_q, avs_writedata, {2'b00, avs_byteenable[1:0]});
                end
                crc_pkg::IDX_XORH: begin
                    poly_d = lane_merge(poly_q, {avs_writedata[15:0], 16'h0000},
                                        {avs_byteenable[1:0], 2'b00});
                end
                crc_pkg::IDX_IRQMASK: begin
                    if (avs_byteenable[0]) begin
                        irq_mask_d = avs_writedata[1:0];
                    end
                end
                default: ;
            endcase
            poly_d[0] = 1'b0;
        end
        if (rd_cap) begin
            case (idx)
                crc_pkg::IDX_CONL: begin
                    rdata_d[crc_pkg::BIT_EN]   = cfg_q.enable;
                    rdata_d[crc_pkg::BIT_SIDL] = cfg_q.stop_in_idle;
                    rdata_d[crc_pkg::BIT_CNT_LO +: 5] = cnt_q;
                    rdata_d[crc_pkg::BIT_FULL]  = fifo_full;
                    rdata_d[crc_pkg::BIT_EMPTY] = fifo_empty;
                    rdata_d[crc_pkg::BIT_ISEL]  = cfg_q.irq_sel;
                    rdata_d[crc_pkg::BIT_GO]    = go_q;
                    rdata_d[crc_pkg::BIT_LSB]   = cfg_q.lsb_first;
                    rdata_d[crc_pkg::BIT_MOD]   = cfg_q.alt_mode;
                end
                crc_pkg::IDX_CONH: begin
                    rdata_d[crc_pkg::BIT_DW_LO +: 5] = cfg_q.data_width_field;
                    rdata_d[4:0] = cfg_q.poly_length_field;
                end
                // The data port is write-only
                crc_pkg::IDX_DATA:    rdata_d = 32'h0000_0000;
                crc_pkg::IDX_XORL:    rdata_d[15:0] = poly_q[15:0];
                crc_pkg::IDX_XORH:    rdata_d[15:0] = poly_q[31:16];
                crc_pkg::IDX_RESULT:  rdata_d = crc_q;
                crc_pkg::IDX_IRQSTAT: rdata_d[1:0] = irq_stat_q;
                crc_pkg::IDX_IRQMASK: rdata_d[1:0] = irq_mask_q;
                default:              rdata_d = 32'h0000_0000;
            endcase
            // Cleared at the capture edge, so the value read is the value wiped
            if (idx == crc_pkg::IDX_IRQSTAT) begin
                irq_stat_d = 2'h0;
            end
        end
        // New events win over the clear-on-read in the same cycle
        if (ev_empty) begin
            irq_stat_d[crc_pkg::IRQ_EMPTY] = 1'b1;
        end
        if (ev_done) begin
            irq_stat_d[crc_pkg::IRQ_DONE] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Configuration, interrupt and bus registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q      <= '0;
            poly_q     <= crc_pkg::POLY_RESET;
            irq_stat_q <= crc_pkg::IRQ_RESET;
            irq_mask_q <= crc_pkg::IRQ_RESET;
            ack_q      <= 1'b0;
            rdata_q    <= 32'h0000_0000;
        end else begin
            cfg_q      <= cfg_d;
            poly_q     <= poly_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            ack_q      <= ack_d;
            rdata_q    <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Engine and FIFO registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q       <= crc_pkg::ST_IDLE;
            go_q       <= 1'b0;
            crc_q      <= 32'h0000_0000;
            word_q     <= 32'h0000_0000;
            bits_q     <= 5'h00;
            rd_ptr_q   <= 4'h0;
            wr_ptr_q   <= 4'h0;
            cnt_q      <= 5'h00;
        end else begin
            st_q       <= st_d;
            go_q       <= go_d;
            crc_q      <= crc_d;
            word_q     <= word_d;
            bits_q     <= bits_d;
            rd_ptr_q   <= rd_ptr_d;
            wr_ptr_q   <= wr_ptr_d;
            cnt_q      <= cnt_d;
        end
    end

    // FIFO storage carries no reset; only the pointers and count matter.
    // Sixteen entries serve both depths: the count, not the pointers, limits it
    always_ff @(posedge clk) begin
        if (push) begin
            fifo_mem[wr_ptr_q] <= avs_writedata;
        end
    end

    assign avs_readdata = rdata_q;
    assign irq          = |(irq_stat_q & irq_mask_q);

endmodule

/* testbench/crc_control_properties.sv */
// Checker for the CRC control block, seen only through its top-level ports
`timescale 1ns/1ps
module crc_control_properties (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        device_idle,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    wire logic req = avs_read || avs_write;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Read data stand in the cycle that ends with the accepting edge
    sequence s_rd(logic [2:0] idx);
        avs_read && !avs_waitrequest && (avs_address[4:2] == idx);
    endsequence
    sequence s_wait_then_held;
        req && avs_waitrequest ##1 req;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_WAIT_FIRST: assert property ($rose(req) |-> avs_waitrequest)
        else $error("first request cycle not stalled");
    AST_ONE_WAIT: assert property (s_wait_then_held |-> !avs_waitrequest)
        else $error("more than one wait state");
    AST_IDLE_NO_WAIT: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest without request");
    AST_RD_ZERO: assert property (!(avs_read && !avs_waitrequest) |-> avs_readdata == 32'h0)
        else $error("read data not cleared");
    AST_EMPTY_CNT: assert property (s_rd(3'h0) |-> avs_readdata[6] == (avs_readdata[12:8] == 5'h0))
        else $error("empty flag disagrees with word count");
    AST_FULL_CNT: assert property (s_rd(3'h0) |-> !avs_readdata[7] || avs_readdata[12:8] >= 5'h08)
        else $error("full flag below smallest depth");
    AST_CNT_MAX: assert property (s_rd(3'h0) |-> avs_readdata[12:8] <= 5'h10)
        else $error("word count above largest depth");
    AST_CTL_UNUSED: assert property (s_rd(3'h0) |-> !avs_readdata[14] && avs_readdata[1:0] == 2'h0)
        else $error("unused control bits not zero");
    AST_POLY_B0: assert property (s_rd(3'h2) |-> !avs_readdata[0])
        else $error("polynomial bit 0 not zero");
    AST_IRQ_RST: assert property ($fell(rst) |-> !irq)
        else $error("interrupt high after reset");
endmodule

bind crc_control crc_control_properties i_crc_control_properties (
    .clk(clk), .rst(rst), .device_idle(device_idle), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq)
);

/* testbench/crc_control_tb.sv */
// Register-level testbench for the CRC control block
`timescale 1ns/1ps
module crc_control_tb;
    logic        clk;
    logic        rst;
    logic        device_idle;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic [31:0] rd;
    int          n_fail;
    int          check_count;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    crc_control i_crc_control (
        .clk(clk), .rst(rst), .device_idle(device_idle), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Request held until waitrequest is sampled low; read data taken at that same edge
    task automatic bus(input logic wr, input logic [2:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= {idx, 2'h0};
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= wd;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                n_fail++;
                end_of_test();
            end
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rchk(input logic [2:0] idx, input logic [31:0] exp, input string name);
        bus(1'b0, idx, 32'h0);
        chk(name, exp, rd);
    endtask

    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            bus(1'b1, 3'h4, 32'h0000_00a5 + 32'(i));
        end
    endtask

    // Starts the shifter and polls until the FIFO is empty and start has dropped
    task automatic drain(input logic [31:0] ctl);
        int n = 0;
        bus(1'b1, 3'h0, ctl);
        do begin
            bus(1'b0, 3'h0, 32'h0);
            n++;
        end while ((rd[6] !== 1'b1 || rd[4] !== 1'b0) && n < 300);
        if (n >= 300) begin
            n_fail++;
            end_of_test();
        end
        chk("ctl_after_drain", (ctl & 32'hffff_ffef) | 32'h0000_0040, rd);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        device_idle = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        n_fail = 0;
        check_count = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rchk(3'h0, 32'h0000_0040, "ctl_low_reset");
        rchk(3'h1, 32'h0000_0000, "ctl_high_reset");
        rchk(3'h6, 32'h0000_0000, "irq_stat_reset");
        chk("irq_reset", 32'h0, {31'h0, irq});
        $display("reset test ended");
        bus(1'b1, 3'h2, 32'hffff_ffff);
        rchk(3'h2, 32'h0000_fffe, "poly_low");
        bus(1'b1, 3'h3, 32'hffff_ffff);
        rchk(3'h3, 32'h0000_ffff, "poly_high");
        bus(1'b1, 3'h1, 32'hffff_ffff);
        rchk(3'h1, 32'h0000_1f1f, "ctl_high");
        bus(1'b1, 3'h5, 32'h1234_abcd);
        rchk(3'h5, 32'h1234_abcd, "result_seed");
        rchk(3'h4, 32'h0000_0000, "data_read");
        $display("register test ended");
        // Short polynomial: sixteen words, seventeenth dropped
        bus(1'b1, 3'h1, 32'h0000_0706);
        push(17);
        rchk(3'h0, 32'h0000_1080, "fifo_full_16");
        bus(1'b1, 3'h7, 32'h0000_0003);
        drain(32'h0000_8010);
        chk("irq_done", 32'h1, {31'h0, irq});
        rchk(3'h6, 32'h0000_0002, "stat_done");
        chk("irq_cleared", 32'h0, {31'h0, irq});
        // Length setting 7 takes the smaller depth
        bus(1'b1, 3'h1, 32'h0000_0707);
        push(9);
        rchk(3'h0, 32'h0000_8880, "fifo_full_8");
        bus(1'b1, 3'h7, 32'h0000_0000);
        drain(32'h0000_8030);
        chk("irq_masked", 32'h0, {31'h0, irq});
        bus(1'b1, 3'h7, 32'h0000_0001);
        @(posedge clk);
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        rchk(3'h6, 32'h0000_0001, "stat_empty");
        chk("irq_cleared2", 32'h0, {31'h0, irq});
        $display("fifo test ended");
        // Idle with stop-in-idle set halts; without it the shifter runs on
        @(posedge clk);
        device_idle <= 1'b1;
        push(1);
        bus(1'b1, 3'h0, 32'h0000_a010);
        repeat (40) @(posedge clk);
        rchk(3'h0, 32'h0000_a110, "idle_halt");
        drain(32'h0000_801c);
        @(posedge clk);
        device_idle <= 1'b0;
        // Disabled module keeps its word and drops start
        push(1);
        bus(1'b1, 3'h0, 32'h0000_0010);
        repeat (40) @(posedge clk);
        rchk(3'h0, 32'h0000_0100, "disabled_hold");
        drain(32'h0000_8014);
        $display("control test ended");
        // Eight-bit code x^8+x^2+x+1, x^0 implied, zero seed, byte 0x01 MSB first
        bus(1'b1, 3'h2, 32'h0000_0006);
        bus(1'b1, 3'h3, 32'h0000_0000);
        bus(1'b1, 3'h5, 32'h0000_0000);
        bus(1'b1, 3'h4, 32'h0000_0001);
        drain(32'h0000_8010);
        rchk(3'h5, 32'h0000_0007, "crc8_msb_first");
        // The mirrored byte shifted LSB first must give the same code
        bus(1'b1, 3'h5, 32'h0000_0000);
        bus(1'b1, 3'h4, 32'h0000_0080);
        drain(32'h0000_8018);
        rchk(3'h5, 32'h0000_0007, "crc8_lsb_first");
        $display("crc test ended");
        end_of_test();
    end
endmodule
